// >>> pkg/table_read_pkg.sv
// constants, states and carrier structs for the table read unit
// assumes one 10 MHz core clock and an 11-bit program address
package table_read_pkg;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int PM_AW = 11;
  localparam int PM_DW = 15;
  localparam int DM_DW = 8;
  localparam int DM_AW = 8;
  localparam int HIGH_W = PM_DW - DM_DW;
  localparam logic [2:0] LAST_PAGE_BITS = 3'h7;

  // ---------------------------------------------------------------
  // data memory map
  // ---------------------------------------------------------------
  localparam logic [DM_AW-1:0] SFR_TBLP_ADDR = 8'h07;
  localparam logic [DM_AW-1:0] SFR_HIGH_ADDR = 8'h08;
  localparam logic [DM_AW-1:0] SFR_NVC_ADDR = 8'h40;
  localparam logic [DM_AW-1:0] GP_BASE_ADDR = 8'h60;
  localparam int GP_DEPTH = 160;
  localparam logic NVC_BANK = 1'b1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DM_DW-1:0] TBLP_RST = 8'h00;
  localparam logic [DM_DW-1:0] HIGH_RST = 8'h00;
  localparam logic [DM_DW-1:0] NVC_RST = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TABLE = 1'b1
  } tbl_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_set;
    logic bit_clr;
    logic [2:0] bit_sel;
    logic bank;
    logic [DM_AW-1:0] addr;
    logic [DM_DW-1:0] wdata;
  } dm_access_t;

  typedef struct packed {
    logic req;
    logic last_page;
    logic dest_bank;
    logic [DM_AW-1:0] dest;
  } tbl_req_t;

endpackage

// >>> rtl/gp_ram.sv
// banked general purpose data memory, 8 bits wide
// assumes the caller has already checked the address is in range
`timescale 1ns/1ns
module gp_ram (
  // clock
  input wire logic i_clk_sys,
  // access
  input wire logic i_we,
  input wire logic i_bank,
  input wire logic [table_read_pkg::DM_AW-1:0] i_index,
  input wire logic [table_read_pkg::DM_DW-1:0] i_wdata,
  output logic [table_read_pkg::DM_DW-1:0] o_rdata
);

  logic [table_read_pkg::DM_DW-1:0] mem_bank0 [table_read_pkg::GP_DEPTH];
  logic [table_read_pkg::DM_DW-1:0] mem_bank1 [table_read_pkg::GP_DEPTH];

  // async read so bit set and clear can modify in one cycle
  assign o_rdata = i_bank ? mem_bank1[i_index] : mem_bank0[i_index];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we && !i_bank)
    begin
      mem_bank0[i_index] <= i_wdata;
    end
    if (i_we && i_bank)
    begin
      mem_bank1[i_index] <= i_wdata;
    end
  end

endmodule

// >>> rtl/program_memory_table_read.sv
// table read unit with the special function registers it owns
// assumes program memory reads combinationally from o_pm_addr and
// the core stalls while o_hold is high
`timescale 1ns/1ns
module program_memory_table_read (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // core requests
  input wire table_read_pkg::tbl_req_t i_tbl,
  input wire table_read_pkg::dm_access_t i_dm,
  input wire logic [table_read_pkg::PM_AW-1:0] i_pc,
  // program memory
  input wire logic [table_read_pkg::PM_DW-1:0] i_pm_data,
  output logic [table_read_pkg::PM_AW-1:0] o_pm_addr,
  // status to core
  output logic o_hold,
  output logic o_done,
  output logic [table_read_pkg::DM_DW-1:0] o_dm_rdata,
  output logic [table_read_pkg::DM_DW-1:0] o_table_high_byte,
  output logic [table_read_pkg::DM_DW-1:0] o_nonvolatile_control
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  table_read_pkg::tbl_state_t state_reg;
  logic [table_read_pkg::DM_DW-1:0] tblp_reg;
  logic [table_read_pkg::DM_DW-1:0] high_reg;
  logic [table_read_pkg::DM_DW-1:0] nvc_reg;
  logic [table_read_pkg::PM_AW-1:0] pm_addr_reg;
  logic [table_read_pkg::DM_AW-1:0] dest_reg;
  logic dest_bank_reg;
  logic hold_reg;
  logic done_reg;
  logic [table_read_pkg::DM_DW-1:0] rdata_reg;

  logic start;
  logic [table_read_pkg::PM_AW-1:0] table_addr;
  logic wr_en;
  logic wr_bank;
  logic [table_read_pkg::DM_AW-1:0] wr_addr;
  logic [table_read_pkg::DM_DW-1:0] wr_data;
  logic [table_read_pkg::DM_DW-1:0] cur_value;
  logic [table_read_pkg::DM_DW-1:0] ram_rdata;
  logic [table_read_pkg::DM_DW-1:0] bit_mask;
  logic in_gp;
  logic [table_read_pkg::DM_AW-1:0] gp_index;

  // requests arriving mid-transfer are dropped; the core is held then
  assign start = i_tbl.req && (state_reg == table_read_pkg::ST_IDLE);

  // ---------------------------------------------------------------
  // table address
  // ---------------------------------------------------------------
  assign table_addr = i_tbl.last_page
    ? {table_read_pkg::LAST_PAGE_BITS, tblp_reg}
    : {i_pc[10:8], tblp_reg};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= table_read_pkg::ST_IDLE;
      hold_reg <= 1'b0;
      done_reg <= 1'b0;
      dest_reg <= 8'h00;
      dest_bank_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (state_reg == table_read_pkg::ST_TABLE);
      if (start)
      begin
        state_reg <= table_read_pkg::ST_TABLE;
        hold_reg <= 1'b1;
        dest_reg <= i_tbl.dest;
        dest_bank_reg <= i_tbl.dest_bank;
      end
      else
      begin
        state_reg <= table_read_pkg::ST_IDLE;
        hold_reg <= 1'b0;
      end
    end
  end

  // program port serves the table word for one cycle, then fetches again
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pm_addr_reg <= 11'h000;
    end
    else if (start)
    begin
      pm_addr_reg <= table_addr;
    end
    else
    begin
      pm_addr_reg <= i_pc;
    end
  end

  // ---------------------------------------------------------------
  // data memory access
  // ---------------------------------------------------------------
  assign in_gp = (wr_addr >= table_read_pkg::GP_BASE_ADDR);
  assign gp_index = wr_addr - table_read_pkg::GP_BASE_ADDR;
  assign bit_mask = 8'h01 << i_dm.bit_sel;

  // special registers ignore the bank, except nonvolatile control
  always_comb
  begin
    cur_value = 8'h00;
    case (wr_addr)
      table_read_pkg::SFR_TBLP_ADDR: cur_value = tblp_reg;
      table_read_pkg::SFR_HIGH_ADDR: cur_value = high_reg;
      table_read_pkg::SFR_NVC_ADDR:
      begin
        if (wr_bank == table_read_pkg::NVC_BANK)
        begin
          cur_value = nvc_reg;
        end
      end
      default:
      begin
        if (in_gp)
        begin
          cur_value = ram_rdata;
        end
      end
    endcase
  end

  // table transfer owns the write port while the core is held
  always_comb
  begin
    wr_en = 1'b0;
    wr_bank = i_dm.bank;
    wr_addr = i_dm.addr;
    wr_data = i_dm.wdata;
    if (state_reg == table_read_pkg::ST_TABLE)
    begin
      wr_en = 1'b1;
      wr_bank = dest_bank_reg;
      wr_addr = dest_reg;
      wr_data = i_pm_data[7:0];
    end
    else if (i_dm.wr)
    begin
      wr_en = 1'b1;
    end
    else if (i_dm.bit_set)
    begin
      wr_en = 1'b1;
      wr_data = cur_value | bit_mask;
    end
    else if (i_dm.bit_clr)
    begin
      wr_en = 1'b1;
      wr_data = cur_value & ~bit_mask;
    end
  end

  gp_ram u_gp_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(wr_en && in_gp),
    .i_bank(wr_bank),
    .i_index(gp_index),
    .i_wdata(wr_data),
    .o_rdata(ram_rdata)
  );

  // ---------------------------------------------------------------
  // special registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tblp_reg <= table_read_pkg::TBLP_RST;
    end
    else if (wr_en && (wr_addr == table_read_pkg::SFR_TBLP_ADDR))
    begin
      tblp_reg <= wr_data;
    end
  end

  // only the table transfer loads it, so it cannot be saved and restored
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      high_reg <= table_read_pkg::HIGH_RST;
    end
    else if (state_reg == table_read_pkg::ST_TABLE)
    begin
      high_reg <= {1'b0, i_pm_data[14:8]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      nvc_reg <= table_read_pkg::NVC_RST;
    end
    else if (wr_en && (wr_addr == table_read_pkg::SFR_NVC_ADDR)
             && (wr_bank == table_read_pkg::NVC_BANK))
    begin
      nvc_reg <= wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_reg <= 8'h00;
    end
    else if (i_dm.rd && (state_reg == table_read_pkg::ST_IDLE))
    begin
      rdata_reg <= cur_value;
    end
  end

  assign o_pm_addr = pm_addr_reg;
  assign o_hold = hold_reg;
  assign o_done = done_reg;
  assign o_dm_rdata = rdata_reg;
  assign o_table_high_byte = high_reg;
  assign o_nonvolatile_control = nvc_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pointer_low_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> o_pm_addr[7:0] == $past(tblp_reg))
    else $error("table address low byte differs from pointer");

  a_current_page: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start && !i_tbl.last_page |=> o_pm_addr[10:8] == $past(i_pc[10:8]))
    else $error("current page bits not from program counter");

  a_last_page: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start && i_tbl.last_page |=> o_pm_addr[10:8] == table_read_pkg::LAST_PAGE_BITS)
    else $error("last page bits not all one");

  a_high_byte_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == table_read_pkg::ST_TABLE |=>
      o_table_high_byte == {1'b0, $past(i_pm_data[14:8])})
    else $error("high byte not loaded from program word");

  a_high_bit_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_table_high_byte[7] == 1'b0)
    else $error("unused high byte bit not zero");

  a_high_read_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == table_read_pkg::ST_IDLE |=> $stable(o_table_high_byte))
    else $error("high byte changed outside a table read");

  a_two_cycle_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> o_hold ##1 (!o_hold && o_done))
    else $error("table read not two cycles");

  a_fetch_resumes: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> ##1 o_pm_addr == $past(i_pc))
    else $error("fetch did not resume after table cycle");

  a_nvc_bank_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_dm.rd && !i_dm.bank && i_dm.addr == table_read_pkg::SFR_NVC_ADDR
      && state_reg == table_read_pkg::ST_IDLE |=> o_dm_rdata == 8'h00)
    else $error("nonvolatile control visible in bank 0");

endmodule

// >>> verif/pm_rom_model.sv
// program memory model for the table read bench
// assumes the unit reads it combinationally from the address it drives
`timescale 1ns/1ns
module pm_rom_model (
  // program port
  input wire logic [table_read_pkg::PM_AW-1:0] i_addr,
  output logic [table_read_pkg::PM_DW-1:0] o_data
);
  // 2K words of 15 bits; contents derived from the address: the low byte is
  // address bits 7:0 xor 3c and the high bits are address bits 10:4
  always_comb
  begin
    o_data = {i_addr[10:4], i_addr[7:0] ^ 8'h3c};
  end
endmodule

// >>> verif/program_memory_table_read_tb.sv
// self-checking bench for the table read unit
// assumes a combinational program memory model and one 10 MHz clock
`timescale 1ns/1ns
module program_memory_table_read_tb;
  logic i_clk_sys;
  logic i_rst_n;
  table_read_pkg::tbl_req_t tbl;
  table_read_pkg::dm_access_t dm;
  logic [10:0] pc;
  logic [14:0] pm_data;
  logic [10:0] pm_addr;
  logic hold;
  logic done;
  logic [7:0] rdata;
  logic [7:0] high;
  logic [7:0] nvc;
  int error_cnt;
  int comparisons;

  program_memory_table_read uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_tbl(tbl),
    .i_dm(dm), .i_pc(pc), .i_pm_data(pm_data), .o_pm_addr(pm_addr), .o_hold(hold),
    .o_done(done), .o_dm_rdata(rdata), .o_table_high_byte(high),
    .o_nonvolatile_control(nvc));
  pm_rom_model rom (.i_addr(pm_addr), .o_data(pm_data));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [14:0] rom_word(logic [10:0] a);
    return {a[10:4], a[7:0] ^ 8'h3c};
  endfunction

  task automatic cyc();
  begin
    @(posedge i_clk_sys);
    #10;
  end
  endtask

  task automatic chk_val(string name, logic [15:0] exp, logic [15:0] got);
  begin
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  end
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
  begin
    chk_val(name, {15'h0000, exp}, {15'h0000, got});
  end
  endtask

  // the access stays on the bus until the next task replaces it,
  // so back-to-back accesses never assign dm twice in one step
  task automatic dm_op(logic [3:0] kind, logic [2:0] sel, logic bank, logic [7:0] a,
                       logic [7:0] d);
  begin
    dm = {kind, sel, bank, a, d};
    cyc();
  end
  endtask

  task automatic rd_chk(string name, logic bank, logic [7:0] a, logic [7:0] exp);
  begin
    dm_op(4'h8, 3'h0, bank, a, 8'h00);
    chk_val(name, {8'h00, exp}, {8'h00, rdata});
  end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // table reads never nest here, so the shared high byte is never
  // overwritten before it is checked
  task automatic tread(logic last, logic bank, logic [7:0] dest, logic [7:0] tp,
                       logic [10:0] pcv);
    logic [10:0] a;
    logic [14:0] w;
  begin
    a = {last ? 3'h7 : pcv[10:8], tp};
    w = rom_word(a);
    dm_op(4'h4, 3'h0, 1'b0, table_read_pkg::SFR_TBLP_ADDR, tp);
    dm = '0;
    pc = pcv;
    tbl = {1'b1, last, bank, dest};
    cyc();
    chk_bit("hold", 1'b1, hold);
    chk_val("table addr", {5'h00, a}, {5'h00, pm_addr});
    pc = pcv + 11'h001;
    // core write during the held cycle must be ignored
    dm = {4'h4, 3'h0, 1'b0, table_read_pkg::SFR_TBLP_ADDR, ~tp};
    // request left high across the busy edge must be ignored
    cyc();
    tbl = '0;
    dm = '0;
    chk_bit("hold end", 1'b0, hold);
    chk_bit("done", 1'b1, done);
    chk_val("high byte", {9'h000, w[14:8]}, {8'h00, high});
    chk_val("fetch addr", {5'h00, pcv + 11'h001}, {5'h00, pm_addr});
    cyc();
    chk_bit("done pulse", 1'b0, done);
    chk_bit("no restart", 1'b0, hold);
    rd_chk("dest byte", bank, dest, w[7:0]);
    rd_chk("ptr kept", 1'b0, table_read_pkg::SFR_TBLP_ADDR, tp);
  end
  endtask

  task automatic s_readonly();
    logic [7:0] h;
  begin
    h = high;
    dm_op(4'h4, 3'h0, 1'b0, table_read_pkg::SFR_HIGH_ADDR, ~h);
    dm_op(4'h2, 3'h7, 1'b1, table_read_pkg::SFR_HIGH_ADDR, 8'h00);
    chk_val("high kept", {8'h00, h}, {8'h00, high});
    rd_chk("high read", 1'b0, table_read_pkg::SFR_HIGH_ADDR, h);
  end
  endtask

  task automatic s_banks();
  begin
    dm_op(4'h4, 3'h0, 1'b0, 8'h40, 8'ha5);
    rd_chk("nvc bank0", 1'b0, 8'h40, 8'h00);
    chk_val("nvc reg", 16'h0000, {8'h00, nvc});
    dm_op(4'h4, 3'h0, 1'b1, 8'h40, 8'ha5);
    rd_chk("nvc bank1", 1'b1, 8'h40, 8'ha5);
    chk_val("nvc out", 16'h00a5, {8'h00, nvc});
    dm_op(4'h4, 3'h0, 1'b1, table_read_pkg::SFR_TBLP_ADDR, 8'h33);
    rd_chk("ptr bank0", 1'b0, table_read_pkg::SFR_TBLP_ADDR, 8'h33);
    dm_op(4'h4, 3'h0, 1'b0, 8'h10, 8'h77);
    rd_chk("unmapped", 1'b0, 8'h10, 8'h00);
    dm_op(4'h4, 3'h0, 1'b0, 8'h60, 8'h11);
    dm_op(4'h4, 3'h0, 1'b1, 8'h60, 8'h22);
    rd_chk("gp bank0", 1'b0, 8'h60, 8'h11);
    rd_chk("gp bank1", 1'b1, 8'h60, 8'h22);
  end
  endtask

  task automatic s_bits();
  begin
    dm_op(4'h4, 3'h0, 1'b0, 8'h62, 8'h00);
    dm_op(4'h2, 3'h3, 1'b0, 8'h62, 8'h00);
    dm_op(4'h2, 3'h7, 1'b0, 8'h62, 8'h00);
    rd_chk("bit set", 1'b0, 8'h62, 8'h88);
    dm_op(4'h4, 3'h0, 1'b0, 8'hff, 8'hff);
    dm_op(4'h1, 3'h0, 1'b0, 8'hff, 8'h00);
    rd_chk("bit clr", 1'b0, 8'hff, 8'hfe);
  end
  endtask

  task automatic give_verdict();
  begin
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    tbl = '0;
    dm = '0;
    pc = 11'h000;
    repeat (3) cyc();
    i_rst_n = 1'b1;
    chk_bit("idle hold", 1'b0, hold);
    chk_val("reset high", 16'h0000, {8'h00, high});
    cyc();
    tread(1'b0, 1'b0, 8'h60, 8'h96, 11'h5a3);
    tread(1'b0, 1'b1, 8'hff, 8'hff, 11'h2f0);
    tread(1'b1, 1'b0, 8'h61, 8'h06, 11'h123);
    tread(1'b1, 1'b1, 8'ha0, 8'h05, 11'h7ff);
    s_readonly();
    s_banks();
    s_bits();
    dm = '0;
    cyc();
    give_verdict();
  end
endmodule
